// file: src/amcp_config_port.sv
// Function
// - Strap high makes four pins static inputs
// - Parallel chip select picks lanes and serialization
// - Parallel clock pin picks driver current
// - Parallel data-in pin puts chip asleep
// - Parallel data-out pin enables internal termination
// - Strap low makes pins a serial port
// - Sample first sixteen rising edges, ignore more
// - Chip select rising ends the command
// - Word is flag, seven address, eight data
// - Flag low writes data to addressed register
// - Flag high reads back, register unchanged
// - Data out only pulls low
// - Reset bit clears registers, sleeps briefly
// - Reset register write-only, low bits ignored
// - Current field codes select driver current
// - Termination doubles current, host limits usage
// - Output-disable bit turns drivers off
// - Mode codes 0-2 two-lane 16/14/12 bits
`timescale 1ns/1ps
`default_nettype none

module amcp_config_port (
    input wire logic clk, // Core clock, 25 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic sck, // Serial clock from host, link domain
    input wire logic program_mode_strap, // High: parallel, low: serial
    input wire logic cs_n, // Chip select, active low
    input wire logic sdi, // Serial data in
    input wire logic sdo_i, // Data-out pin level
    output logic sdo_o, // Data-out pin drive value, always 0
    output logic sdo_oe_n, // Low while pulling data-out low
    output logic duty_stabilizer_disable, // Stabilizer off
    output logic output_scramble_enable, // Randomizer on
    output logic signed_format_select, // Two's complement
    output logic chip_sleep, // Whole chip asleep
    output logic nap_ch_a, // Channel A napping
    output logic nap_ch_b, // Channel B napping
    output logic [2:0] driver_current_select, // Driver current code
    output logic internal_term_enable, // Internal termination
    output logic output_drive_disable, // Output drivers off
    output logic [2:0] lane_serial_select // Lane and serialization
);

    // ==========================================================
    // Link domain: serial slave on sck
    // The host clock stands still outside frames, so the frame end
    // is taken from the chip select level itself, not an sck edge.
    logic [4:0] bit_cnt_r;
    logic [15:0] shift_r;
    logic [7:0] fmt_r;
    logic [7:0] outc_r;
    logic [7:0] rd_shift_r;
    logic srst_req_r;
    logic serial_en;
    logic [14:0] word15;
    logic [7:0] rd_data;

    // Serial port only when strapped low; cs_n high holds it idle
    assign serial_en = ~program_mode_strap;
    assign word15 = {shift_r[13:0], sdi};

    // Readback source for the address latched so far
    function automatic logic [7:0] reg_read(input logic [6:0] a,
            input logic [7:0] f, input logic [7:0] o);
        logic [7:0] v;
        v = 8'h00;
        if (a == amcp_pkg::ADDR_FORMAT_POWER) begin
            v = f;
        end else if (a == amcp_pkg::ADDR_OUTPUT_CONFIG) begin
            v = o;
        end
        return v; // Reset register reads zero: write-only
    endfunction

    assign rd_data = reg_read(shift_r[6:0], fmt_r, outc_r);

    // Bit counter and input shift on the first sixteen edges
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            bit_cnt_r <= 5'h00;
            shift_r <= 16'h0000;
        end else if (serial_en &&
                bit_cnt_r != amcp_pkg::BIT_COUNT_LAST) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
            shift_r <= {shift_r[14:0], sdi};
        end
    end

    // Readback: load after the address bits, then shift MSB first.
    // Driven on falling edges so each bit is settled at the rise;
    // ones are shifted in so write frames never pull the pin low.
    always_ff @(negedge sck or posedge cs_n) begin
        if (cs_n) begin
            rd_shift_r <= 8'hff;
            sdo_oe_n <= 1'b1;
        end else if (serial_en && shift_r[7] && bit_cnt_r == 5'h08) begin
            // Read flag sits at bit 7 after eight edges
            rd_shift_r <= {rd_data[6:0], 1'b1};
            sdo_oe_n <= rd_data[7];
        end else if (serial_en && bit_cnt_r > 5'h08 &&
                bit_cnt_r < amcp_pkg::BIT_COUNT_LAST) begin
            rd_shift_r <= {rd_shift_r[6:0], 1'b1};
            sdo_oe_n <= rd_shift_r[7];
        end else begin
            sdo_oe_n <= 1'b1;
        end
    end

    // Mode registers, cleared by software reset; the reset request
    // stands until the next sck rising edge, long enough to sync
    always_ff @(posedge sck) begin
        srst_req_r <= 1'b0;
        if (!cs_n && serial_en &&
                bit_cnt_r == amcp_pkg::BIT_COUNT_LAST - 5'h01 &&
                !shift_r[amcp_pkg::CMD_RW_POS - 1]) begin
            if (word15[14:8] == amcp_pkg::ADDR_SOFT_RESET) begin
                if (word15[amcp_pkg::RST_BIT]) begin
                    fmt_r <= amcp_pkg::REG_RESET_VAL;
                    outc_r <= amcp_pkg::REG_RESET_VAL;
                    srst_req_r <= 1'b1;
                end
            end else if (word15[14:8] == amcp_pkg::ADDR_FORMAT_POWER)
                    begin
                fmt_r <= word15[7:0];
            end else if (word15[14:8] == amcp_pkg::ADDR_OUTPUT_CONFIG)
                    begin
                outc_r <= word15[7:0];
            end
        end
    end

    // ==========================================================
    // Core domain: synchronisers
    logic [1:0] strap_s;
    logic [1:0] cs_s;
    logic [1:0] sck_s;
    logic [1:0] sdi_s;
    logic [1:0] sdo_s;
    logic [1:0] tgl_s;
    logic [1:0] wr_s;
    logic tgl_seen_r;
    logic srst_done_r;
    logic [2:0] nap_hold_r;

    // Two flops per crossing; word copies are taken only when the
    // chip select level, itself synchronised, says the registers are still
    always_ff @(posedge clk) begin
        strap_s <= {strap_s[0], program_mode_strap};
        cs_s <= {cs_s[0], cs_n};
        sck_s <= {sck_s[0], sck};
        sdi_s <= {sdi_s[0], sdi};
        sdo_s <= {sdo_s[0], sdo_i};
        tgl_s <= {tgl_s[0], srst_req_r};
        wr_s <= {wr_s[0], cs_n};
    end

    // Software reset: brief sleep of a few core cycles
    always_ff @(posedge clk) begin
        if (rst) begin
            tgl_seen_r <= 1'b0;
            srst_done_r <= 1'b0;
            nap_hold_r <= 3'h0;
        end else begin
            tgl_seen_r <= tgl_s[1];
            if (tgl_s[1] && !tgl_seen_r) begin
                nap_hold_r <= 3'h7;
                srst_done_r <= 1'b1;
            end else if (nap_hold_r != 3'h0) begin
                nap_hold_r <= nap_hold_r - 3'h1;
            end
        end
    end

    // Data-out value is always low: the pin only ever pulls down
    always_ff @(posedge clk) begin
        sdo_o <= 1'b0;
    end

    // Decoded mode outputs; serial copies sampled only while frame
    // is closed (cs_n high, synchronised), so fields are stable
    always_ff @(posedge clk) begin
        if (rst) begin
            duty_stabilizer_disable <= 1'b0;
            output_scramble_enable <= 1'b0;
            signed_format_select <= 1'b0;
            chip_sleep <= 1'b0;
            nap_ch_a <= 1'b0;
            nap_ch_b <= 1'b0;
            driver_current_select <= amcp_pkg::CUR_3P5;
            internal_term_enable <= 1'b0;
            output_drive_disable <= 1'b0;
            lane_serial_select <= amcp_pkg::MODE_2L16;
        end else if (strap_s[1]) begin
            duty_stabilizer_disable <= 1'b0;
            output_scramble_enable <= 1'b0;
            signed_format_select <= 1'b0;
            nap_ch_a <= 1'b0;
            nap_ch_b <= 1'b0;
            output_drive_disable <= 1'b0;
            lane_serial_select <= cs_s[1] ? amcp_pkg::MODE_1L14
                : amcp_pkg::MODE_2L16;
            driver_current_select <= sck_s[1] ? amcp_pkg::CUR_1P75
                : amcp_pkg::CUR_3P5;
            chip_sleep <= sdi_s[1];
            internal_term_enable <= sdo_s[1];
        end else if (wr_s[1] && srst_done_r) begin
            // Serial copies wait for a software reset: reset or parallel values hold before
            duty_stabilizer_disable <= fmt_r[amcp_pkg::FMT_DCS_OFF];
            output_scramble_enable <= fmt_r[amcp_pkg::FMT_SCRAMBLE];
            signed_format_select <= fmt_r[amcp_pkg::FMT_SIGNED];
            chip_sleep <= fmt_r[amcp_pkg::FMT_SLEEP] |
                (nap_hold_r != 3'h0);
            nap_ch_a <= fmt_r[amcp_pkg::FMT_NAP_A];
            nap_ch_b <= fmt_r[amcp_pkg::FMT_NAP_B];
            driver_current_select <= outc_r[7:5];
            internal_term_enable <= outc_r[amcp_pkg::OUT_TERM];
            output_drive_disable <= outc_r[amcp_pkg::OUT_DISABLE];
            lane_serial_select <= outc_r[2:0];
        end
    end

endmodule

`default_nettype wire

// file: src/amcp_pkg.sv
package amcp_pkg;

    // ==========================================================
    // Register map
    localparam logic [6:0] ADDR_SOFT_RESET = 7'h00;
    localparam logic [6:0] ADDR_FORMAT_POWER = 7'h01;
    localparam logic [6:0] ADDR_OUTPUT_CONFIG = 7'h02;
    localparam logic [7:0] REG_RESET_VAL = 8'h00;

    // ==========================================================
    // Command word layout
    localparam int CMD_BITS = 16;
    localparam int CMD_RW_POS = 15;
    localparam int CMD_ADDR_MSB = 14;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_DATA_MSB = 7;
    localparam int CMD_DATA_LSB = 0;
    localparam logic [4:0] BIT_COUNT_LAST = 5'h10;

    // ==========================================================
    // Field positions
    localparam int RST_BIT = 7;
    localparam int FMT_DCS_OFF = 7;
    localparam int FMT_SCRAMBLE = 6;
    localparam int FMT_SIGNED = 5;
    localparam int FMT_SLEEP = 4;
    localparam int FMT_NAP_B = 3;
    localparam int FMT_NAP_A = 0;
    localparam int OUT_CUR_MSB = 7;
    localparam int OUT_CUR_LSB = 5;
    localparam int OUT_TERM = 4;
    localparam int OUT_DISABLE = 3;
    localparam int OUT_MODE_MSB = 2;
    localparam int OUT_MODE_LSB = 0;

    // ==========================================================
    // Codes driven to the output stage
    localparam logic [2:0] CUR_3P5 = 3'h0;
    localparam logic [2:0] CUR_1P75 = 3'h7;
    localparam logic [2:0] MODE_2L16 = 3'h0;
    localparam logic [2:0] MODE_1L14 = 3'h6;

endpackage

// file: verif/amcp_config_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Pin-level checks of the configuration port
module amcp_props (
    input wire logic clk, // Core clock
    input wire logic rst, // Sync reset
    input wire logic program_mode_strap, // Mode strap
    input wire logic cs_n, // Chip select
    input wire logic sck, // Serial clock
    input wire logic sdi, // Data in
    input wire logic sdo_i, // Data-out level
    input wire logic sdo_o, // Data-out value
    input wire logic sdo_oe_n, // Data-out enable
    input wire logic chip_sleep, // Sleep
    input wire logic internal_term_enable, // Termination
    input wire logic [2:0] driver_current_select, // Current
    input wire logic [2:0] lane_serial_select // Lanes
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Eight settled cycles cover the pin synchronizers
    property p_par_lane;
        (program_mode_strap && $stable(cs_n)) [*8] |-> lane_serial_select
            == (cs_n ? amcp_pkg::MODE_1L14 : amcp_pkg::MODE_2L16);
    endproperty
    a_par_lane: assert property (p_par_lane)
        else $error("lane code wrong");
    property p_par_cur;
        (program_mode_strap && $stable(sck)) [*8] |-> driver_current_select
            == (sck ? amcp_pkg::CUR_1P75 : amcp_pkg::CUR_3P5);
    endproperty
    a_par_cur: assert property (p_par_cur)
        else $error("current code wrong");
    property p_par_sleep;
        (program_mode_strap && $stable(sdi)) [*8] |-> chip_sleep == sdi;
    endproperty
    a_par_sleep: assert property (p_par_sleep)
        else $error("sleep wrong");
    property p_par_term;
        (program_mode_strap && $stable(sdo_i)) [*8]
            |-> internal_term_enable == sdo_i;
    endproperty
    a_par_term: assert property (p_par_term)
        else $error("termination wrong");
    property p_par_hiz;
        program_mode_strap [*2] |-> sdo_oe_n;
    endproperty
    a_par_hiz: assert property (p_par_hiz)
        else $error("data-out driven in parallel");
    property p_pull_low;
        !sdo_oe_n |-> !sdo_o;
    endproperty
    a_pull_low: assert property (p_pull_low)
        else $error("data-out driven high");
    property p_idle_release;
        cs_n [*3] |-> sdo_oe_n;
    endproperty
    a_idle_release: assert property (p_idle_release)
        else $error("data-out driven while idle");
    // Decoded state may move only after the frame ends
    property p_frame_stable;
        (!program_mode_strap && !cs_n) [*5] |-> $stable(lane_serial_select)
            && $stable(driver_current_select);
    endproperty
    a_frame_stable: assert property (p_frame_stable)
        else $error("outputs moved in frame");
    c_par_sleep: cover property (program_mode_strap && chip_sleep);
    c_soft_sleep: cover property (!program_mode_strap && chip_sleep);
    c_readback: cover property (!sdo_oe_n);
endmodule
bind amcp_config_port amcp_props amcp_props_i (.clk, .rst,
    .program_mode_strap, .cs_n, .sck, .sdi, .sdo_i, .sdo_o, .sdo_oe_n,
    .chip_sleep, .internal_term_enable, .driver_current_select,
    .lane_serial_select);
`default_nettype wire

// file: verif/amcp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host driving the configuration pins
module amcp_host_model (
    output logic cs_n, // Chip select
    output logic sck, // Parked low outside frames
    output logic sdi, // Host data
    input wire logic sdo_w // Data-out wire, pulled up
);
    // Idle: deselected
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
    end
    // Static levels for parallel mode
    task automatic set_pins(input logic c, input logic k, input logic d);
        cs_n = c;
        sck = k;
        sdi = d;
    endtask
    // Bits at 64 ns each; extra edges past sixteen carry junk
    task automatic xfer(input logic [15:0] cmd, input int extra,
                        output logic [7:0] rd);
        rd = 8'h00;
        #7 cs_n = 1'b0;
        for (int i = 15; i >= -extra; i--) begin
            sdi = (i >= 0) ? cmd[i] : ~sdi;
            #32 sck = 1'b1;
            if (i >= 0 && i < 8) begin
                rd = {rd[6:0], sdo_w};
            end
            #32 sck = 1'b0;
        end
        #32 cs_n = 1'b1;
        sdi = ~sdi;
    endtask
endmodule
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bench for the configuration port
module testbench;
    logic clk, rst, strap, par_sdo, sdo_o, sdo_oe_n;
    wire logic cs_n, sck, sdi, sdo_w;
    wire logic [13:0] outs;
    logic [7:0] f, o, rd;
    logic [3:0] p;
    int err_count, checks_done;
    // Pull-up on data-out; parallel mode drives it as input
    assign sdo_w = strap ? par_sdo : (sdo_oe_n ? 1'b1 : sdo_o);
    amcp_config_port amcp_config_port_i (.clk(clk), .rst(rst), .sck(sck),
        .program_mode_strap(strap), .cs_n(cs_n), .sdi(sdi), .sdo_i(sdo_w),
        .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n),
        .duty_stabilizer_disable(outs[13]), .output_scramble_enable(outs[12]),
        .signed_format_select(outs[11]), .chip_sleep(outs[10]),
        .nap_ch_b(outs[9]), .nap_ch_a(outs[8]),
        .driver_current_select(outs[7:5]), .internal_term_enable(outs[4]),
        .output_drive_disable(outs[3]), .lane_serial_select(outs[2:0]));
    amcp_host_model amcp_host_model_i (.cs_n(cs_n), .sck(sck), .sdi(sdi),
        .sdo_w(sdo_w));
    // Expected decode of both modes
    function automatic logic [13:0] exp_ser(input logic [7:0] a, b);
        exp_ser = {a[7:3], a[0], b};
    endfunction
    function automatic logic [13:0] par_exp(input logic [3:0] v);
        par_exp = {6'h00, v[1], v[2] ? amcp_pkg::CUR_1P75 : amcp_pkg::CUR_3P5,
            v[0], v[3] ? amcp_pkg::MODE_1L14 : amcp_pkg::MODE_2L16};
    endfunction
    task automatic check(input string n, input logic [13:0] s, e);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Frames are spaced well past decode and sleep time
    task automatic xf(input logic [15:0] c, input int x);
        amcp_host_model_i.xfer(c, x, rd);
        repeat (16) @(negedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #2000000 err_count++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        rst = 1'b1;
        strap = 1'b1;
        par_sdo = 1'b0;
        err_count = 0;
        checks_done = 0;
        void'($urandom(32'had60_6a64));
        repeat (4) @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 16; i++) begin
            p = i[3:0];
            amcp_host_model_i.set_pins(p[3], p[2], p[1]);
            par_sdo = p[0];
            repeat (12) @(negedge clk);
            check("par", {6'h00, outs[10], outs[7:4], outs[2:0]},
                par_exp(p));
        end
        amcp_host_model_i.set_pins(1'b1, 1'b0, 1'b0);
        strap = 1'b0;
        repeat (10) @(negedge clk);
        xf(16'h0080, 0);
        check("srst", outs, 14'h0000);
        for (int n = 0; n < 12; n++) begin
            f = 8'($urandom);
            o = 8'($urandom);
            if (o[4]) o[7:5] = 3'h5 + {2'b00, o[5]};
            xf({1'b0, amcp_pkg::ADDR_FORMAT_POWER, f}, n % 3);
            xf({1'b0, amcp_pkg::ADDR_OUTPUT_CONFIG, o}, 0);
            xf({9'h000, 7'($urandom)}, 0);
            xf({9'h00a, 7'($urandom)}, 0);
            xf({1'b1, amcp_pkg::ADDR_FORMAT_POWER, 8'($urandom)}, 0);
            check("rd1", {6'h00, rd}, {6'h00, f});
            xf({1'b1, amcp_pkg::ADDR_OUTPUT_CONFIG, 8'($urandom)}, 0);
            check("rd2", {6'h00, rd}, {6'h00, o});
            check("dec", outs, exp_ser(f, o));
        end
        xf({9'h001, 7'($urandom)}, 0);
        check("srst2", outs, 14'h0000);
        report_and_stop();
    end
endmodule
`default_nettype wire
